// ===== hw/cpuex_file_mem.sv
// file register memory with registered read data
`default_nettype none
module cpuex_file_mem
  import cpuex_pkg::*;
#(
  parameter int unsigned DEPTH = FILE_DEPTH
) (
  // clock
  input  wire logic              clk_sys,
  // write port
  input  wire cpuex_wr_t         wr,
  // read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output var  logic [DATA_W-1:0] rd_data_q
);
  logic [DATA_W-1:0] mem_q [DEPTH];

  // no reset on the array: contents are defined by preload before use
  always_ff @(posedge clk_sys) begin
    if (wr.en) begin
      mem_q[wr.addr] <= wr.data;
    end
    rd_data_q <= mem_q[rd_addr];
  end
endmodule
`default_nettype wire

// ===== hw/cpuex_pkg.sv
// shared constants and types for the execution subset
`default_nettype none
package cpuex_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned K_W        = 11;
  localparam int unsigned PC_W       = 13;
  localparam int unsigned LATCH_W    = 8;
  localparam int unsigned LATCH_HI   = 4;
  localparam int unsigned LATCH_LO   = 3;
  localparam int unsigned FILE_DEPTH = 128;
  // clocks per instruction cycle
  localparam int unsigned CYC_CLKS   = 4;
  localparam int unsigned CNT_W      = 2;
  localparam logic [CNT_W-1:0] CNT_LAST = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 2'h1;
  localparam logic [DATA_W-1:0] W_RST   = 8'h00;
  localparam logic [DATA_W-1:0] ONE_B   = 8'h01;
  localparam logic [PC_W-1:0]  PC_RST   = 13'h0000;
  localparam logic [PC_W-1:0]  PC_ONE   = 13'h0001;
  localparam logic             DEST_W   = 1'b0;
  localparam logic             DEST_F   = 1'b1;

  typedef enum logic [2:0] {
    LONG_JUMP_OP     = 3'h0,
    INC_SKIP_ZERO_OP = 3'h1,
    INC_FILE_OP      = 3'h2,
    OR_LITERAL_OP    = 3'h3,
    OR_FILE_OP       = 3'h4,
    SHIFT_LEFT_OP    = 3'h5
  } cpuex_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_EXTRA = 3'b100
  } cpuex_state_t;

  typedef struct packed {
    cpuex_op_t         op;
    logic [K_W-1:0]    k;
    logic [ADDR_W-1:0] faddr;
    logic              dest;
  } cpuex_req_t;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cpuex_wr_t;
endpackage
`default_nettype wire

// ===== hw/cpuex_top.sv
// execution unit for the jump, increment, or and left shift subset
`default_nettype none
module cpuex_top
  import cpuex_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // instruction request
  input  wire logic               req_valid,
  input  wire cpuex_req_t         req,
  output var  logic               req_ready_q,
  output var  logic               done_q,
  // upper page latch contents
  input  wire logic [LATCH_W-1:0] upper_page_latch,
  // preload of file registers and accumulator, taken while idle
  input  wire cpuex_wr_t          file_load,
  input  wire logic               w_load_en,
  input  wire logic [DATA_W-1:0]  w_load_data,
  // inspection of a file register while idle
  input  wire logic [ADDR_W-1:0]  peek_addr,
  output var  logic [DATA_W-1:0]  peek_data_q,
  // architectural state
  output var  logic [PC_W-1:0]    pc_q,
  output var  logic [DATA_W-1:0]  w_q,
  output var  logic               carry_q,
  output var  logic               zero_q,
  output var  logic               no_operation_q
);
  cpuex_state_t      st_q,    st_d;
  logic [CNT_W-1:0]  cnt_q,   cnt_d;
  cpuex_req_t        op_q,    op_d;
  logic [PC_W-1:0]   pc_d;
  logic [DATA_W-1:0] w_d;
  logic              carry_d, zero_d, done_d, ready_d, nop_d;
  logic              skip_q,  skip_d;
  logic [DATA_W-1:0] res;
  logic [DATA_W-1:0] fdata;
  logic [ADDR_W-1:0] rd_addr;
  logic              writes_dest;
  cpuex_wr_t         wr;
  logic              cyc_end;

  // end of an instruction cycle: the counter divides the clock by four
  // and restarts on each accepted request, so timing is request-relative
  assign cyc_end = (cnt_q == CNT_LAST);

  // idle reads follow the peek address, busy reads the operand; the
  // registered read data settle by the second busy clock, well before
  // the result edge
  assign rd_addr = (st_q == ST_IDLE) ? peek_addr : op_q.faddr;

  cpuex_file_mem #(
    .DEPTH     (FILE_DEPTH)
  ) u_mem (
    .clk_sys   (clk_sys),
    .wr        (wr),
    .rd_addr   (rd_addr),
    .rd_data_q (fdata)
  );

  assign peek_data_q = fdata;

  // result of the operation in flight
  // increment wraps to zero, which is exactly what the skip tests
  always_comb begin
    res         = fdata;
    writes_dest = 1'b1;
    unique case (op_q.op)
      INC_SKIP_ZERO_OP,
      INC_FILE_OP:   res = DATA_W'(fdata + ONE_B);
      OR_LITERAL_OP: res = w_q | op_q.k[DATA_W-1:0];
      OR_FILE_OP:    res = w_q | fdata;
      SHIFT_LEFT_OP: res = {fdata[DATA_W-2:0], 1'b0};
      LONG_JUMP_OP:  writes_dest = 1'b0;
      default:       writes_dest = 1'b0;
    endcase
  end

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    op_d    = op_q;
    pc_d    = pc_q;
    w_d     = w_q;
    carry_d = carry_q;
    zero_d  = zero_q;
    skip_d  = skip_q;
    done_d  = 1'b0;
    nop_d   = 1'b0;
    wr      = file_load;
    wr.en   = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        // preload only while idle: a write racing a busy instruction
        // could clobber its operand between read and result
        wr.en = file_load.en;
        if (w_load_en) begin
          w_d = w_load_data;
        end
        if (req_valid) begin
          op_d  = req;
          cnt_d = CNT_ZERO;
          st_d  = ST_EXEC;
        end
      end
      ST_EXEC: begin
        cnt_d = cnt_q + CNT_ONE;
        if (cyc_end) begin
          // every result lands on one edge so pc, flags and file agree
          wr.addr = op_q.faddr;
          wr.data = res;
          if (writes_dest) begin
            // literal or always lands in the accumulator
            if (op_q.op == OR_LITERAL_OP || op_q.dest == DEST_W) begin
              w_d = res;
            end else begin
              wr.en = 1'b1;
            end
          end
          unique case (op_q.op)
            INC_FILE_OP, OR_LITERAL_OP, OR_FILE_OP: begin
              zero_d = (res == W_RST);
            end
            SHIFT_LEFT_OP: begin
              // carry comes from the operand, not the shifted result
              carry_d = fdata[DATA_W-1];
              zero_d  = (res == W_RST);
            end
            default: begin
              // jump and increment-skip leave the flags alone
            end
          endcase
          // remembered so the extra cycle knows to step pc past the word
          skip_d = (op_q.op == INC_SKIP_ZERO_OP) && (res == W_RST);
          if (op_q.op == LONG_JUMP_OP) begin
            // latch is read at the result edge, not at acceptance, so it
            // must be settled by the result edge, not when the jump is issued
            pc_d = {upper_page_latch[LATCH_HI:LATCH_LO],
                    op_q.k};
            st_d = ST_EXTRA;
          end else begin
            // no fetch unit here: pc steps once per executed word
            pc_d = pc_q + PC_ONE;
            if (op_q.op == INC_SKIP_ZERO_OP && res == W_RST) begin
              st_d = ST_EXTRA;
            end else begin
              st_d   = ST_IDLE;
              done_d = 1'b1;
            end
          end
        end
      end
      ST_EXTRA: begin
        // second cycle of a jump or taken skip; a jump only waits here,
        // standing in for the flush of the word fetched behind it
        cnt_d = cnt_q + CNT_ONE;
        if (cyc_end) begin
          // the skipped word is consumed as a no-operation
          if (skip_q) begin
            pc_d  = pc_q + PC_ONE;
            nop_d = 1'b1;
          end
          skip_d = 1'b0;
          st_d   = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        // an illegal one-hot code falls back to idle instead of hanging
        st_d = ST_IDLE;
      end
    endcase
    ready_d = (st_d == ST_IDLE);
  end

  // handshake pulses share the state register stage, so every output
  // leaves straight from a flip-flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q           <= ST_IDLE;
      cnt_q          <= CNT_ZERO;
      op_q           <= '0;
      pc_q           <= PC_RST;
      w_q            <= W_RST;
      carry_q        <= 1'b0;
      zero_q         <= 1'b0;
      skip_q         <= 1'b0;
      done_q         <= 1'b0;
      no_operation_q <= 1'b0;
      req_ready_q    <= 1'b1;
    end else begin
      st_q           <= st_d;
      cnt_q          <= cnt_d;
      op_q           <= op_d;
      pc_q           <= pc_d;
      w_q            <= w_d;
      carry_q        <= carry_d;
      zero_q         <= zero_d;
      skip_q         <= skip_d;
      done_q         <= done_d;
      no_operation_q <= nop_d;
      req_ready_q    <= ready_d;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/cpuex_top_bench.sv
// self-checking bench for the execution unit
`default_nettype none
module cpuex_top_bench
  import cpuex_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               req_valid = 1'b0;
  logic               w_load_en = 1'b0;
  logic [DATA_W-1:0]  w_load_data = 8'h00;
  logic [ADDR_W-1:0]  peek_addr = 7'h00;
  logic [LATCH_W-1:0] upper_page_latch = 8'h00;
  cpuex_req_t         req = '0;
  cpuex_wr_t          file_load = '0;
  logic               req_ready_q, done_q, carry_q, zero_q, no_operation_q;
  logic [DATA_W-1:0]  peek_data_q, w_q;
  logic [PC_W-1:0]    pc_q;
  logic               no_operation;
  int                 fail_count = 0, n_checks = 0, cyc;

  cpuex_top dut (.clk_sys, .rst_n, .req_valid, .req, .req_ready_q, .done_q,
    .upper_page_latch, .file_load, .w_load_en, .w_load_data, .peek_addr,
    .peek_data_q, .pc_q, .w_q, .carry_q, .zero_q, .no_operation_q);

  always #5 clk_sys = ~clk_sys;

  task automatic chk(logic [12:0] got, logic [12:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // preload happens only while idle, so callers stay between runs
  task automatic ld(logic [6:0] a, logic [7:0] d, logic [7:0] w);
    @(posedge clk_sys); #1;
    file_load = '{1'b1, a, d};
    w_load_en = 1'b1;
    w_load_data = w;
    @(posedge clk_sys); #1;
    file_load.en = 1'b0;
    w_load_en = 1'b0;
  endtask
  task automatic run(cpuex_op_t o, logic [10:0] k, logic [6:0] f, logic d);
    @(posedge clk_sys); #1;
    req_valid = 1'b1;
    req = '{o, k, f, d};
    @(posedge clk_sys); #1;
    req_valid = 1'b0;
    cyc = 0;
    while (done_q !== 1'b1 && cyc < 20) begin
      @(posedge clk_sys); #1;
      cyc++;
    end
    no_operation = no_operation_q;
    if (done_q !== 1'b1) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, done_q, 1'b1);
    end
  endtask
  task automatic peek(logic [6:0] a);
    peek_addr = a;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk({carry_q, zero_q, w_q}, 10'h000);
    ld(7'h05, 8'hFF, 8'h00);
    run(INC_FILE_OP, 11'h000, 7'h05, DEST_F);
    chk({zero_q, 4'h0, cyc[3:0]}, 9'h104);
    peek(7'h05);
    chk(peek_data_q, 8'h00);
    ld(7'h06, 8'h41, 8'h00);
    run(INC_FILE_OP, 11'h000, 7'h06, DEST_W);
    chk({zero_q, w_q}, 9'h042);
    $display("test increment ended");
    ld(7'h07, 8'hFF, 8'h00);
    run(INC_SKIP_ZERO_OP, 11'h000, 7'h07, DEST_F);
    chk({no_operation, zero_q, cyc[3:0]}, 6'h28);
    chk(pc_q, 13'h0004);
    peek(7'h07);
    chk(peek_data_q, 8'h00);
    run(INC_SKIP_ZERO_OP, 11'h000, 7'h07, DEST_W);
    chk({no_operation, w_q, cyc[3:0]}, 13'h0014);
    $display("test skip ended");
    run(OR_LITERAL_OP, 11'h780, 7'h00, DEST_F);
    chk({zero_q, w_q}, 9'h081);
    ld(7'h00, 8'h00, 8'h00);
    run(OR_LITERAL_OP, 11'h000, 7'h00, DEST_W);
    chk({zero_q, w_q}, 9'h100);
    ld(7'h7F, 8'hF0, 8'h0F);
    run(OR_FILE_OP, 11'h000, 7'h7F, DEST_F);
    chk({zero_q, w_q}, 9'h00F);
    peek(7'h7F);
    chk(peek_data_q, 8'hFF);
    run(OR_FILE_OP, 11'h000, 7'h7F, DEST_W);
    chk(w_q, 8'hFF);
    $display("test or ended");
    ld(7'h00, 8'h81, 8'h00);
    run(SHIFT_LEFT_OP, 11'h000, 7'h00, DEST_F);
    chk({carry_q, zero_q, w_q}, 10'h200);
    peek(7'h00);
    chk(peek_data_q, 8'h02);
    ld(7'h01, 8'h80, 8'hAA);
    run(SHIFT_LEFT_OP, 11'h000, 7'h01, DEST_W);
    chk({carry_q, zero_q, w_q}, 10'h300);
    chk(pc_q, 13'h000B);
    $display("test shift ended");
    upper_page_latch = 8'h18;
    run(LONG_JUMP_OP, 11'h7FF, 7'h00, DEST_W);
    chk({carry_q, zero_q, 7'h00, cyc[3:0]}, 13'h1808);
    chk(pc_q, 13'h1FFF);
    upper_page_latch = 8'hE7;
    run(LONG_JUMP_OP, 11'h555, 7'h00, DEST_W);
    chk(pc_q, 13'h0555);
    $display("test jump ended");
    final_report();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire

// ===== testbench/cpuex_top_props.sv
// port-level assertions for the execution unit
`default_nettype none
module cpuex_top_props
  import cpuex_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic               req_valid,
  input wire cpuex_req_t         req,
  input wire logic               req_ready_q,
  input wire logic               done_q,
  input wire logic [LATCH_W-1:0] upper_page_latch,
  input wire logic [PC_W-1:0]    pc_q,
  input wire logic [DATA_W-1:0]  w_q,
  input wire logic               carry_q,
  input wire logic               zero_q,
  input wire logic               no_operation_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_take(cpuex_op_t o);
    req_valid && req_ready_q && req.op == o;
  endsequence
  a_jump_target: assert property (s_take(LONG_JUMP_OP)
    |-> ##5 pc_q == {$past(upper_page_latch[4:3]), $past(req.k, 5)})
    else $error("jump target wrong");
  a_jump_time: assert property (s_take(LONG_JUMP_OP) |->
    ##1 !done_q [*8] ##1 done_q) else $error("jump length wrong");
  a_skip_flags: assert property (s_take(INC_SKIP_ZERO_OP) |->
    ##1 ($stable(zero_q) && $stable(carry_q)) [*8])
    else $error("skip changed a flag");
  a_skip_extra: assert property (s_take(INC_SKIP_ZERO_OP)
    ##5 !done_q |-> ##4 done_q && no_operation_q)
    else $error("skip cycle wrong");
  a_single_time: assert property (s_take(req.op) ##0
    req.op inside {INC_FILE_OP, OR_LITERAL_OP, OR_FILE_OP, SHIFT_LEFT_OP}
    |-> ##1 !req_ready_q [*4] ##1 done_q && req_ready_q)
    else $error("single cycle op length wrong");
  a_lit_or: assert property (s_take(OR_LITERAL_OP) |-> ##5
    w_q == ($past(w_q, 5) | $past(req.k[7:0], 5)) && zero_q == (w_q == 8'h00))
    else $error("or literal result wrong");
  a_shift_w: assert property (s_take(SHIFT_LEFT_OP)
    ##0 !req.dest |-> ##5 !w_q[0] && zero_q == (w_q == 8'h00))
    else $error("shift wrong");
  a_inc_zero: assert property (s_take(INC_FILE_OP) ##0 !req.dest
    |-> ##5 zero_q == (w_q == 8'h00)) else $error("increment zero wrong");
  a_file_keeps_w: assert property (s_take(OR_FILE_OP) ##0 req.dest
    |-> ##5 $stable(w_q)) else $error("file dest touched w");
endmodule
bind cpuex_top cpuex_top_props u_props (.clk_sys, .rst_n, .req_valid, .req,
  .req_ready_q, .done_q, .upper_page_latch, .pc_q, .w_q, .carry_q, .zero_q,
  .no_operation_q);
`default_nettype wire
